/* sim/paq_switch_model.sv */
// switch driver load fed by the two pwm outputs
// assumes clk_sys and arst_n of the block under test
`timescale 1ns/10ps
module paq_switch_model
(
	// clock and reset
	input  wire logic        clk_sys,
	input  wire logic        arst_n,
	// gate drive
	input  wire logic        gateA,
	input  wire logic        gateB,
	// cycles with both switches on
	output logic [15:0]      overlapCount
);
	always_ff @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
			overlapCount <= 16'h0000;
		else if (gateA && gateB)
			overlapCount <= overlapCount + 16'h0001;
	end
endmodule : paq_switch_model

/* sim/tb_pwm_action_qualifier_ctrl.sv */
// self-checking bench for the pwm action qualifier
// assumes the package, design and switch model are compiled first
`timescale 1ns/10ps
module tb_pwm_action_qualifier_ctrl
	import paq_pkg::*;
;
	logic        clk_sys = 1'h0;
	logic        arst_n  = 1'h0;
	paq_events_t ev      = '0;
	logic [11:0] awAddr  = 12'h000;
	logic [11:0] arAddr  = 12'h000;
	logic [31:0] wData   = 32'h0;
	logic        awValid = 1'h0;
	logic        wValid  = 1'h0;
	logic        bReady  = 1'h0;
	logic        arValid = 1'h0;
	logic        rReady  = 1'h0;
	logic [3:0]  wStrb   = 4'hf;
	logic [15:0] overlap;
	logic        awReady, wReady, bValid, arReady, rValid, outA, outB;
	logic [1:0]  bResp, rResp, r;
	logic [31:0] rData, d;
	logic [15:0] regA = 16'h0;
	logic [15:0] regB = 16'h0;
	logic        expA = 1'h0;
	logic        expB = 1'h0;
	int          num_errors = 0;
	int          checks_done = 0;

	always #50 clk_sys = ~clk_sys;

	paq_action_qualifier u_paq_action_qualifier (.clk_sys(clk_sys),
		.arst_n(arst_n), .tbEvents(ev), .s_axi_awaddr(awAddr),
		.s_axi_awvalid(awValid), .s_axi_awready(awReady),
		.s_axi_wdata(wData), .s_axi_wstrb(wStrb), .s_axi_wvalid(wValid),
		.s_axi_wready(wReady), .s_axi_bresp(bResp), .s_axi_bvalid(bValid),
		.s_axi_bready(bReady), .s_axi_araddr(arAddr),
		.s_axi_arvalid(arValid), .s_axi_arready(arReady),
		.s_axi_rdata(rData), .s_axi_rresp(rResp), .s_axi_rvalid(rValid),
		.s_axi_rready(rReady), .pwm_output_a(outA), .pwm_output_b(outB));

	paq_switch_model u_paq_switch_model (.clk_sys(clk_sys),
		.arst_n(arst_n), .gateA(outA), .gateB(outB),
		.overlapCount(overlap));

	// next output level; later lines win, so they hold the higher priority
	function automatic logic nxt(logic [15:0] c, paq_events_t e, logic q);
		logic       dn;
		logic [1:0] a;
		dn = !e.countUp;
		if (e.upDownMode && e.period)
			dn = 1'h1;
		if (e.upDownMode && e.zero)
			dn = 1'h0;
		a = 2'h0;
		if (e.zero && |c[1:0])
			a = c[1:0];
		if (e.period && |c[3:2])
			a = c[3:2];
		if (e.compare_a_value && !dn && |c[5:4])
			a = c[5:4];
		if (e.compare_a_value && dn && |c[7:6])
			a = c[7:6];
		if (e.compare_b_value && !dn && |c[9:8])
			a = c[9:8];
		if (e.compare_b_value && dn && |c[11:10])
			a = c[11:10];
		case (a)
			2'h1: return 1'h0;
			2'h2: return 1'h1;
			2'h3: return !q;
			default: return q;
		endcase
	endfunction : nxt

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("CHECK FAILED at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask : check

	task automatic wr(input logic [11:0] a, input logic [31:0] v);
		bit b;
		b = 1'b0;
		@(posedge clk_sys);
		awAddr <= a;
		wData <= v;
		awValid <= 1'h1;
		wValid <= 1'h1;
		bReady <= 1'h1;
		while (!b)
		begin
			@(posedge clk_sys);
			if (awValid && awReady)
				awValid <= 1'h0;
			if (wValid && wReady)
				wValid <= 1'h0;
			if (bValid)
			begin
				r = bResp;
				bReady <= 1'h0;
				b = 1'b1;
			end
		end
	endtask : wr

	task automatic rd(input logic [11:0] a);
		bit b;
		b = 1'b0;
		@(posedge clk_sys);
		arAddr <= a;
		arValid <= 1'h1;
		rReady <= 1'h1;
		while (!b)
		begin
			@(posedge clk_sys);
			if (arValid && arReady)
				arValid <= 1'h0;
			if (rValid)
			begin
				d = rData;
				r = rResp;
				rReady <= 1'h0;
				b = 1'b1;
			end
		end
	endtask : rd

	task automatic fire(input paq_events_t e);
		@(posedge clk_sys);
		ev <= e;
		expA = nxt(regA, e, expA);
		expB = nxt(regB, e, expB);
		@(posedge clk_sys);
		ev <= '0;
		@(negedge clk_sys);
		check(32'(outA), 32'(expA));
		check(32'(outB), 32'(expB));
	endtask : fire

	task automatic setRegs(input logic [31:0] va, input logic [31:0] vb);
		wr(PAQ_OFS_ACT_A, va);
		wr(PAQ_OFS_ACT_B, vb);
		regA = va[15:0] & PAQ_ACT_MASK;
		regB = vb[15:0] & PAQ_ACT_MASK;
	endtask : setRegs

	task automatic print_verdict;
		$display("checks %0d errors %0d overlap %0d", checks_done,
			num_errors, overlap);
		if (num_errors == 0 && checks_done > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : print_verdict

	initial
	begin
		#3000000;
		num_errors++;
		print_verdict();
	end

	initial
	begin
		paq_events_t e;
		void'($urandom(18480));
		repeat (2) @(posedge clk_sys);
		arst_n <= 1'h1;
		rd(PAQ_OFS_ACT_A);
		check(d, 32'h0);
		rd(PAQ_OFS_ACT_B);
		check(d, 32'h0);
		setRegs(32'hffffffff, 32'hffffffff);
		rd(PAQ_OFS_ACT_B);
		check(d, 32'h00000fff);
		// only the upper lane is strobed: the low byte must survive
		wStrb <= 4'h2;
		wr(PAQ_OFS_ACT_B, 32'h0);
		wStrb <= 4'hf;
		rd(PAQ_OFS_ACT_B);
		check(d, 32'h000000ff);
		rd(12'h00c);
		check(32'(r), 32'(PAQ_RESP_SLVERR));
		check(d, 32'h0);
		wr(PAQ_OFS_STATUS, 32'h0);
		check(32'(r), 32'(PAQ_RESP_SLVERR));
		$display("test registers done");
		for (int p = 0; p < 6; p++)
			for (int c = 0; c < 4; c++)
			begin
				setRegs(32'(c) << (2 * p), 32'(3 - c) << (2 * p));
				e = '0;
				e.zero = (p == 0);
				e.period = (p == 1);
				e.compare_a_value = (p == 2 || p == 3);
				e.compare_b_value = (p > 3);
				e.countUp = !p[0];
				repeat (2) fire(e);
			end
		// up-down overrides: period forces down, zero forces up
		setRegs(32'h00000090, 32'h00000190);
		fire(paq_events_t'(6'h1b));
		fire(paq_events_t'(6'h25));
		fire(paq_events_t'(6'h29));
		$display("test field table done");
		repeat (150)
		begin
			setRegs($urandom, $urandom);
			rd(PAQ_OFS_ACT_A);
			check(d, 32'(regA));
			repeat (4) fire(paq_events_t'($urandom));
			rd(PAQ_OFS_STATUS);
			check(d, {30'h0, expB, expA});
		end
		$display("test random done");
		// reset in mid-run clears outputs and action fields again
		arst_n <= 1'h0;
		repeat (2) @(posedge clk_sys);
		arst_n <= 1'h1;
		rd(PAQ_OFS_STATUS);
		check(d, 32'h0);
		rd(PAQ_OFS_ACT_A);
		check(d, 32'h0);
		$display("test reset done");
		print_verdict();
	end
endmodule : tb_pwm_action_qualifier_ctrl

/* src/paq_action_qualifier.sv */
// action qualifier: counter events steer two pwm outputs, with an
// AXI4-Lite register slave; events come from a time base on clk_sys
`timescale 1ns/10ps
module paq_action_qualifier
	import paq_pkg::*;
(
	// clock and reset
	input  wire logic        clk_sys,
	input  wire logic        arst_n,
	// counter events
	input  wire paq_events_t tbEvents,
	// axi4-lite write address and data
	input  wire logic [11:0] s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	// axi4-lite write response
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	// axi4-lite read
	input  wire logic [11:0] s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	// pwm outputs
	output logic             pwm_output_a,
	output logic             pwm_output_b
);

	logic [15:0] actA_reg;
	logic [15:0] actB_reg;
	logic [11:0] wAddr_reg;
	logic [31:0] wData_reg;
	logic [3:0]  wStrb_reg;
	logic        haveAw_reg;
	logic        haveW_reg;
	logic        doWrite;
	logic [11:0] addrW;
	logic [15:0] actA_next;
	logic [15:0] actB_next;
	paq_action_t selA;
	paq_action_t selB;

	// fixed priority: compare B down, B up, A down, A up, period, zero
	function automatic paq_action_t pick
	(
		input logic [15:0] act,
		input paq_events_t ev
	);
		logic dirUp;
		logic [1:0] f;
		dirUp = ev.countUp;
		f = 2'h0;
		if (ev.upDownMode && ev.period)
			dirUp = 1'b0;
		if (ev.upDownMode && ev.zero)
			dirUp = 1'b1;
		if (ev.zero && act[PAQ_POS_ZERO +: 2] != 2'h0)
			f = act[PAQ_POS_ZERO +: 2];
		if (ev.period && act[PAQ_POS_PERIOD +: 2] != 2'h0)
			f = act[PAQ_POS_PERIOD +: 2];
		if (ev.compare_a_value && dirUp && act[PAQ_POS_CA_UP +: 2] != 2'h0)
			f = act[PAQ_POS_CA_UP +: 2];
		if (ev.compare_a_value && !dirUp && act[PAQ_POS_CA_DOWN +: 2] != 2'h0)
			f = act[PAQ_POS_CA_DOWN +: 2];
		if (ev.compare_b_value && dirUp && act[PAQ_POS_CB_UP +: 2] != 2'h0)
			f = act[PAQ_POS_CB_UP +: 2];
		if (ev.compare_b_value && !dirUp && act[PAQ_POS_CB_DOWN +: 2] != 2'h0)
			f = act[PAQ_POS_CB_DOWN +: 2];
		return paq_action_t'(f);
	endfunction : pick

	function automatic logic apply
	(
		input paq_action_t a,
		input logic cur
	);
		logic r;
		r = cur;
		unique case (a)
			PAQ_ACT_NONE:   r = cur;
			PAQ_ACT_CLEAR:  r = 1'b0;
			PAQ_ACT_SET:    r = 1'b1;
			PAQ_ACT_TOGGLE: r = !cur;
		endcase
		return r;
	endfunction : apply

	assign selA = pick(actA_reg, tbEvents);
	assign selB = pick(actB_reg, tbEvents);

	always_ff @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
			pwm_output_a <= 1'b0;
		else if (selA != PAQ_ACT_NONE)
			pwm_output_a <= apply(selA, pwm_output_a);
	end

	always_ff @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
			pwm_output_b <= 1'b0;
		else if (selB != PAQ_ACT_NONE)
			pwm_output_b <= apply(selB, pwm_output_b);
	end

	// write channel: address and data taken in either order
	always_ff @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
		begin
			haveAw_reg <= 1'b0;
			haveW_reg  <= 1'b0;
			wAddr_reg  <= 12'h000;
			wData_reg  <= 32'h00000000;
			wStrb_reg  <= 4'h0;
		end
		else
		begin
			if (s_axi_awvalid && s_axi_awready)
			begin
				haveAw_reg <= 1'b1;
				wAddr_reg  <= s_axi_awaddr;
			end
			else if (doWrite)
				haveAw_reg <= 1'b0;
			if (s_axi_wvalid && s_axi_wready)
			begin
				haveW_reg <= 1'b1;
				wData_reg <= s_axi_wdata;
				wStrb_reg <= s_axi_wstrb;
			end
			else if (doWrite)
				haveW_reg <= 1'b0;
		end
	end

	assign doWrite = haveAw_reg && haveW_reg && !s_axi_bvalid;
	assign addrW   = {wAddr_reg[11:2], 2'h0};

	always_ff @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
		begin
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
		end
		else
		begin
			s_axi_awready <= !haveAw_reg && !s_axi_awready &&
				!(s_axi_awvalid && s_axi_awready);
			s_axi_wready  <= !haveW_reg && !s_axi_wready &&
				!(s_axi_wvalid && s_axi_wready);
		end
	end

	always_comb
	begin
		actA_next = actA_reg;
		actB_next = actB_reg;
		if (doWrite && addrW == PAQ_OFS_ACT_A)
		begin
			if (wStrb_reg[0])
				actA_next[7:0] = wData_reg[7:0];
			if (wStrb_reg[1])
				actA_next[15:8] = wData_reg[15:8];
		end
		if (doWrite && addrW == PAQ_OFS_ACT_B)
		begin
			if (wStrb_reg[0])
				actB_next[7:0] = wData_reg[7:0];
			if (wStrb_reg[1])
				actB_next[15:8] = wData_reg[15:8];
		end
		actA_next = actA_next & PAQ_ACT_MASK;
		actB_next = actB_next & PAQ_ACT_MASK;
	end

	always_ff @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
		begin
			actA_reg <= PAQ_ACT_RESET;
			actB_reg <= PAQ_ACT_RESET;
		end
		else
		begin
			actA_reg <= actA_next;
			actB_reg <= actB_next;
		end
	end

	always_ff @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
		begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= PAQ_RESP_OKAY;
		end
		else if (doWrite)
		begin
			s_axi_bvalid <= 1'b1;
			if (addrW == PAQ_OFS_ACT_A || addrW == PAQ_OFS_ACT_B)
				s_axi_bresp <= PAQ_RESP_OKAY;
			else
				s_axi_bresp <= PAQ_RESP_SLVERR;
		end
		else if (s_axi_bready)
			s_axi_bvalid <= 1'b0;
	end

	// read channel: one cycle of arready, data the cycle after
	always_ff @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
		begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h00000000;
			s_axi_rresp   <= PAQ_RESP_OKAY;
		end
		else
		begin
			s_axi_arready <= !s_axi_arready && !s_axi_rvalid;
			if (s_axi_arvalid && s_axi_arready)
			begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp  <= PAQ_RESP_OKAY;
				unique case ({s_axi_araddr[11:2], 2'h0})
					PAQ_OFS_ACT_A:  s_axi_rdata <= {16'h0000, actA_reg};
					PAQ_OFS_ACT_B:  s_axi_rdata <= {16'h0000, actB_reg};
					PAQ_OFS_STATUS: s_axi_rdata <= {30'h0,
						pwm_output_b, pwm_output_a};
					default:
					begin
						s_axi_rdata <= 32'h00000000;
						s_axi_rresp <= PAQ_RESP_SLVERR;
					end
				endcase
			end
			else if (s_axi_rready)
				s_axi_rvalid <= 1'b0;
		end
	end

	a_resv_zero: assert property (
		@(posedge clk_sys) disable iff (!arst_n)
		actA_reg[15:12] == 4'h0 && actB_reg[15:12] == 4'h0)
		else $error("reserved action bits not zero");

	a_zero_set: assert property (
		@(posedge clk_sys) disable iff (!arst_n)
		tbEvents.zero && !tbEvents.period && !tbEvents.compare_a_value &&
		!tbEvents.compare_b_value && actA_reg[1:0] == 2'h2 |=> pwm_output_a)
		else $error("zero set did not raise output a");

	a_zero_clear: assert property (
		@(posedge clk_sys) disable iff (!arst_n)
		tbEvents.zero && !tbEvents.period && !tbEvents.compare_a_value &&
		!tbEvents.compare_b_value && actB_reg[1:0] == 2'h1 |=> !pwm_output_b)
		else $error("zero clear did not lower output b");

	a_period_tog: assert property (
		@(posedge clk_sys) disable iff (!arst_n)
		tbEvents.period && !tbEvents.compare_a_value && !tbEvents.compare_b_value &&
		actA_reg[3:2] == 2'h3 |=> pwm_output_a != $past(pwm_output_a))
		else $error("period toggle failed");

	a_hold_idle: assert property (
		@(posedge clk_sys) disable iff (!arst_n)
		!(tbEvents.zero || tbEvents.period || tbEvents.compare_a_value ||
		tbEvents.compare_b_value) |=> $stable(pwm_output_a) && $stable(pwm_output_b))
		else $error("output moved without an event");

	a_cbd_set: assert property (
		@(posedge clk_sys) disable iff (!arst_n)
		tbEvents.compare_b_value && !tbEvents.countUp && !tbEvents.upDownMode &&
		actA_reg[11:10] == 2'h2 |=> pwm_output_a)
		else $error("compare b down set failed");

	a_cbu_clr: assert property (
		@(posedge clk_sys) disable iff (!arst_n)
		tbEvents.compare_b_value && tbEvents.countUp && !tbEvents.upDownMode &&
		actB_reg[9:8] == 2'h1 |=> !pwm_output_b)
		else $error("compare b up clear failed");

	a_cad_set: assert property (
		@(posedge clk_sys) disable iff (!arst_n)
		tbEvents.compare_a_value && !tbEvents.compare_b_value && !tbEvents.countUp &&
		!tbEvents.upDownMode && actB_reg[7:6] == 2'h2 |=> pwm_output_b)
		else $error("compare a down set failed");

	a_cau_clr: assert property (
		@(posedge clk_sys) disable iff (!arst_n)
		tbEvents.compare_a_value && !tbEvents.compare_b_value && tbEvents.countUp &&
		!tbEvents.upDownMode && actA_reg[5:4] == 2'h1 |=> !pwm_output_a)
		else $error("compare a up clear failed");

	// a coinciding zero match wins the direction, so it is excluded here
	a_period_down: assert property (
		@(posedge clk_sys) disable iff (!arst_n)
		!tbEvents.zero && tbEvents.upDownMode && tbEvents.period &&
		tbEvents.compare_a_value && !tbEvents.compare_b_value && tbEvents.countUp &&
		actA_reg[7:6] == 2'h2 |=> pwm_output_a)
		else $error("period match not taken as down");

	a_zero_up: assert property (
		@(posedge clk_sys) disable iff (!arst_n)
		tbEvents.upDownMode && tbEvents.zero && tbEvents.compare_b_value &&
		!tbEvents.countUp && actB_reg[9:8] == 2'h1 |=> !pwm_output_b)
		else $error("zero match not taken as up");

	a_none_hold: assert property (
		@(posedge clk_sys) disable iff (!arst_n)
		tbEvents.zero && !tbEvents.period && !tbEvents.compare_a_value &&
		!tbEvents.compare_b_value && actA_reg[1:0] == 2'h0 |=> $stable(pwm_output_a))
		else $error("disabled zero action moved output a");

	a_b_toggle: assert property (
		@(posedge clk_sys) disable iff (!arst_n)
		tbEvents.period && !tbEvents.compare_a_value && !tbEvents.compare_b_value &&
		actB_reg[3:2] == 2'h3 |=> pwm_output_b != $past(pwm_output_b))
		else $error("period toggle failed on output b");

	a_cbd_prio: assert property (
		@(posedge clk_sys) disable iff (!arst_n)
		tbEvents.compare_b_value && !tbEvents.countUp && !tbEvents.upDownMode &&
		actB_reg[11:10] == 2'h1 |=> !pwm_output_b)
		else $error("compare b down lost its priority");

	a_write_lands: assert property (
		@(posedge clk_sys) disable iff (!arst_n)
		doWrite && addrW == PAQ_OFS_ACT_A && wStrb_reg[1:0] == 2'h3
		|=> actA_reg == ($past(wData_reg[15:0]) & PAQ_ACT_MASK))
		else $error("write to action register a did not land");

	a_lane_keep: assert property (
		@(posedge clk_sys) disable iff (!arst_n)
		doWrite && addrW == PAQ_OFS_ACT_B && wStrb_reg[1:0] == 2'h2
		|=> actB_reg[7:0] == $past(actB_reg[7:0]))
		else $error("unstrobed byte lane of register b changed");

	a_rd_upper: assert property (
		@(posedge clk_sys) disable iff (!arst_n)
		s_axi_rvalid |-> s_axi_rdata[31:12] == 20'h00000)
		else $error("read data upper bits not zero");

endmodule : paq_action_qualifier

/* src/paq_pkg.sv */
// constants, field layout and bus types for the pwm action qualifier
// assumes one 10 MHz system clock and an AXI4-Lite register master
package paq_pkg;

	localparam logic [11:0] PAQ_OFS_ACT_A   = 12'h000;
	localparam logic [11:0] PAQ_OFS_ACT_B   = 12'h004;
	localparam logic [11:0] PAQ_OFS_STATUS  = 12'h008;
	localparam logic [15:0] PAQ_ACT_RESET   = 16'h0000;
	localparam logic [15:0] PAQ_ACT_MASK    = 16'h0fff;
	localparam int          PAQ_POS_ZERO    = 0;
	localparam int          PAQ_POS_PERIOD  = 2;
	localparam int          PAQ_POS_CA_UP   = 4;
	localparam int          PAQ_POS_CA_DOWN = 6;
	localparam int          PAQ_POS_CB_UP   = 8;
	localparam int          PAQ_POS_CB_DOWN = 10;
	localparam logic [1:0]  PAQ_RESP_OKAY   = 2'h0;
	localparam logic [1:0]  PAQ_RESP_SLVERR = 2'h2;

	typedef enum logic [1:0]
	{
		PAQ_ACT_NONE   = 2'h0,
		PAQ_ACT_CLEAR  = 2'h1,
		PAQ_ACT_SET    = 2'h2,
		PAQ_ACT_TOGGLE = 2'h3
	} paq_action_t;

	// counter events from the time base, one cycle each
	typedef struct packed
	{
		logic zero;
		logic period;
		logic compare_a_value;
		logic compare_b_value;
		logic countUp;
		logic upDownMode;
	} paq_events_t;

endpackage : paq_pkg
